/* rtl/drive_input_function_select.sv */
`timescale 1ns/10ps
// Behaviour
// - Loss check only for voltage, current, summed analog or keypad source.
// - Criterion 0 never checks the analog level; keypad loss is still declared.
// - Criterion 1: lost while input below half the minimum.
// - Criterion 2: lost while input below the minimum.
// - Declared loss shows an observable indication.
// - Loss declared only after condition persists for the timeout.
// - Action 0 keeps running after loss.
// - Action 1 cuts output at once, motor coasts.
// - Action 2 stops by configured decel pattern and time.
// - Action and timeout also govern keypad command loss.
// - Codes 0, 1, 2 are low, mid, high speed bits.
// - Codes 3, 4, 5 are low, mid, high ramp bits.
// - Code 6 requests DC braking, applied only while stopped.
// - Code 9 switches to voltage input; 10, 11 up/down; 12 three-wire.
// - Code 16 toggles closed-loop and open-loop control.
// - Code 18 freezes the analog reference.
// - Code 19 disables acceleration and deceleration.
// - Codes 15, 17, 20 to 26 do nothing.
// - Speed bits form index selecting step frequency 0 to 7.
// - Jog overrides all other terminal inputs.
// - Ramp bits form index selecting one of eight time pairs.
// - Minimum is the configured voltage or current minimum.
module drive_input_function_select
  import input_select_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic [2:0] i_frequency_source_select,
  input wire logic [1:0] i_loss_criterion,
  input wire logic [1:0] i_loss_action,
  input wire logic [input_select_pkg::TMO_W-1:0] i_loss_timeout,
  input wire logic [input_select_pkg::AIN_W-1:0] i_volt_level,
  input wire logic [input_select_pkg::AIN_W-1:0] i_curr_level,
  input wire logic [input_select_pkg::AIN_W-1:0] i_volt_min,
  input wire logic [input_select_pkg::AIN_W-1:0] i_curr_min,
  input wire logic i_keypad_cmd_lost,
  input wire logic i_drive_stopped,
  input wire logic i_multi_input_a,
  input wire logic i_multi_input_b,
  input wire logic i_multi_input_c,
  input wire logic i_jog_input,
  input wire logic [input_select_pkg::CODE_W-1:0] i_code_a,
  input wire logic [input_select_pkg::CODE_W-1:0] i_code_b,
  input wire logic [input_select_pkg::CODE_W-1:0] i_code_c,
  output logic O_REF_LOST,
  output logic O_LOSS_EVENT,
  output logic O_OUTPUT_CUTOFF,
  output logic O_DECEL_STOP,
  output logic O_JOG_ACTIVE,
  output logic [2:0] O_STEP_INDEX,
  output logic [2:0] O_RAMP_INDEX,
  output logic O_DC_INJECTION_REQUEST,
  output logic O_VOLTAGE_SOURCE_SWITCH,
  output logic O_UP,
  output logic O_DOWN,
  output logic O_THREE_WIRE,
  output logic O_OPEN_LOOP,
  output logic O_ANALOG_HOLD,
  output logic O_RAMP_INHIBIT
);
  import input_select_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
    end else begin
      pin_s1_r <= {i_jog_input, i_multi_input_c, i_multi_input_b,
                   i_multi_input_a};
      pin_s2_r <= pin_s1_r;
    end
  end

  logic [CODE_W-1:0] codes [NUM_TERM];
  assign codes[0] = i_code_a;
  assign codes[1] = i_code_b;
  assign codes[2] = i_code_c;

  term_func_if fn ();
  term_func_decode u_decode (
    .i_level(pin_s2_r[2:0]),
    .i_code(codes),
    .fn(fn.decoder)
  );

  // ----------------------------------------
  // Reference loss detection
  // ----------------------------------------
  logic analog_src;
  logic keypad_src;
  logic below_v;
  logic below_c;
  logic cond_now;
  assign analog_src = (i_frequency_source_select == SRC_VOLT) ||
                      (i_frequency_source_select == SRC_CURR) ||
                      (i_frequency_source_select == SRC_SUM);
  assign keypad_src = (i_frequency_source_select == SRC_KEYPAD1) ||
                      (i_frequency_source_select == SRC_KEYPAD2);

  always_comb begin
    below_v = 1'b0;
    below_c = 1'b0;
    case (i_loss_criterion)
      CRIT_HALF: begin
        below_v = i_volt_level < (i_volt_min >> 1);
        below_c = i_curr_level < (i_curr_min >> 1);
      end
      CRIT_BELOW: begin
        below_v = i_volt_level < i_volt_min;
        below_c = i_curr_level < i_curr_min;
      end
      default: begin
        below_v = 1'b0;
        below_c = 1'b0;
      end
    endcase
  end

  always_comb begin
    cond_now = 1'b0;
    if (keypad_src)
      cond_now = i_keypad_cmd_lost;
    else if (analog_src) begin
      case (i_frequency_source_select)
        SRC_VOLT: cond_now = below_v;
        SRC_CURR: cond_now = below_c;
        default: cond_now = below_v | below_c;
      endcase
    end
  end

  loss_state_t state_r;
  logic [TMO_W-1:0] wait_cnt_r;
  logic lost_nxt;
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      state_r <= LS_OK;
      wait_cnt_r <= '0;
    end else begin
      case (state_r)
        LS_OK: begin
          wait_cnt_r <= TMO_ONE;
          if (cond_now)
            state_r <= (i_loss_timeout <= TMO_ONE) ? LS_LOST : LS_WAIT;
        end
        LS_WAIT: begin
          if (!cond_now)
            state_r <= LS_OK;
          else if (wait_cnt_r + TMO_ONE >= i_loss_timeout)
            state_r <= LS_LOST;
          else
            wait_cnt_r <= wait_cnt_r + TMO_ONE;
        end
        LS_LOST: begin
          if (!cond_now)
            state_r <= LS_OK;
        end
        default: state_r <= LS_OK;
      endcase
    end
  end
  assign lost_nxt = (state_r == LS_LOST);

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_REF_LOST <= 1'b0;
      O_LOSS_EVENT <= 1'b0;
    end else begin
      O_REF_LOST <= lost_nxt;
      O_LOSS_EVENT <= lost_nxt & ~O_REF_LOST;
    end
  end

  // Action re-read from the setting every cycle while lost; no action while running on a lost
  // reference under setting 0
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_OUTPUT_CUTOFF <= 1'b0;
      O_DECEL_STOP <= 1'b0;
    end else begin
      O_OUTPUT_CUTOFF <= 1'b0;
      O_DECEL_STOP <= 1'b0;
      if (lost_nxt) begin
        case (i_loss_action)
          ACT_FREERUN: O_OUTPUT_CUTOFF <= 1'b1;
          ACT_STOP: O_DECEL_STOP <= 1'b1;
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Terminal outputs
  // ----------------------------------------
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_JOG_ACTIVE <= 1'b0;
      O_STEP_INDEX <= 3'h0;
      O_RAMP_INDEX <= 3'h0;
      O_DC_INJECTION_REQUEST <= 1'b0;
      O_VOLTAGE_SOURCE_SWITCH <= 1'b0;
      O_UP <= 1'b0;
      O_DOWN <= 1'b0;
      O_THREE_WIRE <= 1'b0;
      O_OPEN_LOOP <= 1'b0;
      O_ANALOG_HOLD <= 1'b0;
      O_RAMP_INHIBIT <= 1'b0;
    end else begin
      O_JOG_ACTIVE <= pin_s2_r[3];
      O_STEP_INDEX <= pin_s2_r[3] ? 3'h0 : fn.speed_bits;
      O_RAMP_INDEX <= pin_s2_r[3] ? 3'h0 : fn.ramp_bits;
      O_DC_INJECTION_REQUEST <= ~pin_s2_r[3] & fn.dc_req & i_drive_stopped;
      O_VOLTAGE_SOURCE_SWITCH <= ~pin_s2_r[3] & fn.vswitch;
      O_UP <= ~pin_s2_r[3] & fn.up;
      O_DOWN <= ~pin_s2_r[3] & fn.down;
      O_THREE_WIRE <= ~pin_s2_r[3] & fn.three_wire;
      O_OPEN_LOOP <= ~pin_s2_r[3] & fn.open_loop;
      O_ANALOG_HOLD <= ~pin_s2_r[3] & fn.hold;
      O_RAMP_INHIBIT <= ~pin_s2_r[3] & fn.ramp_inhibit;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  no_check_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (i_loss_criterion == CRIT_NONE && !keypad_src) [*3] |-> !O_REF_LOST)
    else $error("loss declared with check disabled");
  src_gate_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (!analog_src && !keypad_src) [*3] |-> !O_REF_LOST)
    else $error("loss declared on non analog source");
  event_edge_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    O_LOSS_EVENT |-> O_REF_LOST && !$past(O_REF_LOST))
    else $error("loss event not on rising indication");
  event_rise_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    $rose(O_REF_LOST) |-> O_LOSS_EVENT)
    else $error("loss indication rose without event");
  persist_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    $rose(O_REF_LOST) |-> $past(cond_now, 2))
    else $error("loss declared without persisting condition");
  lost_clear_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    !cond_now [*2] |=> !O_REF_LOST)
    else $error("loss held after condition cleared");
  cutoff_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (lost_nxt && i_loss_action == ACT_FREERUN) |=> O_OUTPUT_CUTOFF)
    else $error("cutoff missing after loss");
  cut_lost_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    O_OUTPUT_CUTOFF |-> O_REF_LOST)
    else $error("cutoff without declared loss");
  decel_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (lost_nxt && i_loss_action == ACT_STOP) |=> O_DECEL_STOP)
    else $error("decel stop missing after loss");
  run_on_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (i_loss_action == ACT_NONE) |=> !O_OUTPUT_CUTOFF && !O_DECEL_STOP)
    else $error("action taken with action none");
  kp_quiet_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (keypad_src && !i_keypad_cmd_lost) |-> ##2 !O_REF_LOST)
    else $error("keypad loss declared with command present");
  jog_wins_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    O_JOG_ACTIVE |-> O_STEP_INDEX == 3'h0 && !O_UP && !O_DC_INJECTION_REQUEST)
    else $error("jog did not override terminals");
  jog_rest_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    O_JOG_ACTIVE |-> O_RAMP_INDEX == 3'h0 && !O_VOLTAGE_SOURCE_SWITCH &&
    !O_RAMP_INHIBIT && !O_ANALOG_HOLD)
    else $error("jog left other terminal functions active");
  brake_stop_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    O_DC_INJECTION_REQUEST |-> $past(i_drive_stopped))
    else $error("braking while running");
  step_idx_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    !pin_s2_r[3] |=> O_STEP_INDEX == $past(fn.speed_bits))
    else $error("step index mismatch");
  ramp_idx_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    !pin_s2_r[3] |=> O_RAMP_INDEX == $past(fn.ramp_bits))
    else $error("ramp index mismatch");
endmodule // drive_input_function_select

/* shared/input_select_pkg.sv */
package input_select_pkg;
  localparam int CODE_W = 5;
  localparam int AIN_W = 12;
  localparam int TMO_W = 16;
  localparam int NUM_TERM = 3;
  // Frequency source settings
  localparam logic [2:0] SRC_KEYPAD1 = 3'h0;
  localparam logic [2:0] SRC_KEYPAD2 = 3'h1;
  localparam logic [2:0] SRC_VOLT = 3'h2;
  localparam logic [2:0] SRC_CURR = 3'h3;
  localparam logic [2:0] SRC_SUM = 3'h4;
  // Loss criterion settings
  localparam logic [1:0] CRIT_NONE = 2'h0;
  localparam logic [1:0] CRIT_HALF = 2'h1;
  localparam logic [1:0] CRIT_BELOW = 2'h2;
  // Loss action settings
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_FREERUN = 2'h1;
  localparam logic [1:0] ACT_STOP = 2'h2;
  // Terminal function codes
  localparam logic [4:0] FN_SPEED_L = 5'h00;
  localparam logic [4:0] FN_SPEED_M = 5'h01;
  localparam logic [4:0] FN_SPEED_H = 5'h02;
  localparam logic [4:0] FN_RAMP_SELECT_BIT0 = 5'h03;
  localparam logic [4:0] FN_RAMP_SELECT_BIT1 = 5'h04;
  localparam logic [4:0] FN_RAMP_SELECT_BIT2 = 5'h05;
  localparam logic [4:0] FN_DC_INJECTION_REQUEST = 5'h06;
  localparam logic [4:0] FN_VSWITCH = 5'h09;
  localparam logic [4:0] FN_UP = 5'h0A;
  localparam logic [4:0] FN_DOWN = 5'h0B;
  localparam logic [4:0] FN_THREE_WIRE = 5'h0C;
  localparam logic [4:0] FN_OPEN_LOOP = 5'h10;
  localparam logic [4:0] FN_HOLD = 5'h12;
  localparam logic [4:0] FN_RAMP_INHIBIT = 5'h13;
  localparam logic [TMO_W-1:0] TMO_ONE = 16'h0001;
  typedef enum logic [1:0] {
    LS_OK = 2'b00,
    LS_WAIT = 2'b01,
    LS_LOST = 2'b11
  } loss_state_t;
endpackage

/* shared/term_func_if.sv */
`timescale 1ns/10ps
interface term_func_if;
  logic [2:0] speed_bits;
  logic [2:0] ramp_bits;
  logic dc_req;
  logic vswitch;
  logic up;
  logic down;
  logic three_wire;
  logic open_loop;
  logic hold;
  logic ramp_inhibit;
  modport decoder (output speed_bits, ramp_bits, dc_req, vswitch, up, down,
    three_wire, open_loop, hold, ramp_inhibit);
  modport user (input speed_bits, ramp_bits, dc_req, vswitch, up, down,
    three_wire, open_loop, hold, ramp_inhibit);
endinterface

/* rtl/term_func_decode.sv */
`timescale 1ns/10ps
module term_func_decode
  import input_select_pkg::*;
(
  input wire logic [NUM_TERM-1:0] i_level,
  input wire logic [CODE_W-1:0] i_code [NUM_TERM],
  term_func_if.decoder fn
);
  // Reserved codes simply match nothing, and unassigned bits stay 0
  always_comb begin
    fn.speed_bits = 3'h0;
    fn.ramp_bits = 3'h0;
    fn.dc_req = 1'b0;
    fn.vswitch = 1'b0;
    fn.up = 1'b0;
    fn.down = 1'b0;
    fn.three_wire = 1'b0;
    fn.open_loop = 1'b0;
    fn.hold = 1'b0;
    fn.ramp_inhibit = 1'b0;
    for (int t = 0; t < NUM_TERM; t++) begin
      case (i_code[t])
        FN_SPEED_L: fn.speed_bits[0] = fn.speed_bits[0] | i_level[t];
        FN_SPEED_M: fn.speed_bits[1] = fn.speed_bits[1] | i_level[t];
        FN_SPEED_H: fn.speed_bits[2] = fn.speed_bits[2] | i_level[t];
        FN_RAMP_SELECT_BIT0: fn.ramp_bits[0] = fn.ramp_bits[0] | i_level[t];
        FN_RAMP_SELECT_BIT1: fn.ramp_bits[1] = fn.ramp_bits[1] | i_level[t];
        FN_RAMP_SELECT_BIT2: fn.ramp_bits[2] = fn.ramp_bits[2] | i_level[t];
        FN_DC_INJECTION_REQUEST: fn.dc_req = fn.dc_req | i_level[t];
        FN_VSWITCH: fn.vswitch = fn.vswitch | i_level[t];
        FN_UP: fn.up = fn.up | i_level[t];
        FN_DOWN: fn.down = fn.down | i_level[t];
        FN_THREE_WIRE: fn.three_wire = fn.three_wire | i_level[t];
        FN_OPEN_LOOP: fn.open_loop = fn.open_loop | i_level[t];
        FN_HOLD: fn.hold = fn.hold | i_level[t];
        FN_RAMP_INHIBIT: fn.ramp_inhibit = fn.ramp_inhibit | i_level[t];
        default: begin
        end
      endcase
    end
  end
endmodule // term_func_decode

/* dv/switch_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Terminal switches and analog sources
// ----------------------------------------
module switch_model
  import input_select_pkg::*;
(
  input wire logic [2:0] i_want,
  input wire logic [2:0] i_brake_mask,
  input wire logic i_stopped,
  input wire logic [input_select_pkg::AIN_W-1:0] i_volt,
  input wire logic [input_select_pkg::AIN_W-1:0] i_curr,
  output logic [2:0] o_pins,
  output logic [input_select_pkg::AIN_W-1:0] o_volt,
  output logic [input_select_pkg::AIN_W-1:0] o_curr
);
  // braking contact while stopped
  // Operator never closes it while running
  assign o_pins = i_want & ~(i_brake_mask & {3{~i_stopped}});
  assign o_volt = i_volt;
  assign o_curr = i_curr;
endmodule // switch_model

/* dv/drive_input_function_select_bench.sv */
`timescale 1ns/10ps
module drive_input_function_select_bench;
  import input_select_pkg::*;
  logic clk = 1'b0, rst = 1'b1, kp_lost = 1'b0, stopped = 1'b1, jog = 1'b0;
  logic [2:0] src = SRC_VOLT, want = 3'h0, bmask = 3'h0, pins;
  logic [1:0] crit = CRIT_NONE, act = ACT_NONE;
  logic [TMO_W-1:0] tmo = 16'h0003;
  logic [AIN_W-1:0] volt = 12'hFFF, curr = 12'hFFF, av, ac;
  logic [AIN_W-1:0] vmin = 12'h0C8, cmin = 12'h190;
  logic [CODE_W-1:0] ca = 5'h00, cb = 5'h01, cc = 5'h02;
  logic lost, ev, cut, dstop, jact, dcb, vsw, up, dn, tw, ol, hold, inh;
  logic [2:0] sidx, ridx;
  int errors = 0, comparisons = 0, cycles = 0;
  always #10 clk = ~clk;
  switch_model partner (.i_want(want), .i_brake_mask(bmask),
    .i_stopped(stopped), .i_volt(volt), .i_curr(curr), .o_pins(pins),
    .o_volt(av), .o_curr(ac));
  drive_input_function_select DUT (.I_MCLK(clk), .I_RST(rst),
    .i_frequency_source_select(src), .i_loss_criterion(crit),
    .i_loss_action(act), .i_loss_timeout(tmo), .i_volt_level(av),
    .i_curr_level(ac), .i_volt_min(vmin), .i_curr_min(cmin),
    .i_keypad_cmd_lost(kp_lost), .i_drive_stopped(stopped),
    .i_multi_input_a(pins[0]), .i_multi_input_b(pins[1]),
    .i_multi_input_c(pins[2]), .i_jog_input(jog), .i_code_a(ca),
    .i_code_b(cb), .i_code_c(cc), .O_REF_LOST(lost), .O_LOSS_EVENT(ev),
    .O_OUTPUT_CUTOFF(cut), .O_DECEL_STOP(dstop), .O_JOG_ACTIVE(jact),
    .O_STEP_INDEX(sidx), .O_RAMP_INDEX(ridx), .O_DC_INJECTION_REQUEST(dcb),
    .O_VOLTAGE_SOURCE_SWITCH(vsw), .O_UP(up), .O_DOWN(dn),
    .O_THREE_WIRE(tw), .O_OPEN_LOOP(ol), .O_ANALOG_HOLD(hold),
    .O_RAMP_INHIBIT(inh));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  function automatic logic [7:0] fvec();
    return {dcb, vsw, up, dn, tw, ol, hold, inh};
  endfunction
  // ----------------------------------------
  // Speed and ramp selectors
  // ----------------------------------------
  task automatic t_select(input logic ramp);
    ca = ramp ? FN_RAMP_SELECT_BIT0 : FN_SPEED_L;
    cb = ramp ? FN_RAMP_SELECT_BIT1 : FN_SPEED_M;
    cc = ramp ? FN_RAMP_SELECT_BIT2 : FN_SPEED_H;
    for (int i = 0; i < 8; i++) begin
      want = i[2:0];
      wait_n(4);
      check(ramp ? ridx : sidx, {13'h0, want});
      check(ramp ? sidx : ridx, 16'h0000);
    end
  endtask
  // ----------------------------------------
  // Single-bit terminal functions
  // ----------------------------------------
  task automatic t_funcs();
    logic [4:0] codes [12] = '{FN_DC_INJECTION_REQUEST, FN_VSWITCH, FN_UP, FN_DOWN,
      FN_THREE_WIRE, FN_OPEN_LOOP, FN_HOLD, FN_RAMP_INHIBIT, 5'h0F, 5'h11,
      5'h14, 5'h1A};
    cb = 5'h0F;
    cc = 5'h11;
    want = 3'h1;
    for (int i = 0; i < 12; i++) begin
      ca = codes[i];
      wait_n(4);
      check(fvec(), (i < 8) ? 16'h0080 >> i : 16'h0000);
    end
    ca = FN_DC_INJECTION_REQUEST;
    bmask = 3'h1;
    stopped = 1'b0;
    // Synchronised pin still high here, so only the stop gate holds it
    wait_n(1);
    check(dcb, 16'h0000);
    wait_n(3);
    check(dcb, 16'h0000);
    stopped = 1'b1;
    bmask = 3'h0;
    ca = FN_VSWITCH;
    cb = FN_SPEED_M;
    want = 3'h3;
    jog = 1'b1;
    wait_n(4);
    check({jact, sidx, fvec()}, 16'h0800);
    jog = 1'b0;
    wait_n(4);
    check({jact, sidx, fvec()}, 16'h0240);
    want = 3'h0;
  endtask
  // ----------------------------------------
  // Reference loss with a timeout of 3
  // ----------------------------------------
  task automatic t_loss(input logic [2:0] s, input logic [1:0] c,
    input logic [1:0] a, input logic [11:0] v, input logic [11:0] i,
    input logic k, input logic exp);
    src = s;
    crit = c;
    act = a;
    volt = v;
    curr = i;
    kp_lost = k;
    wait_n(3);
    check({lost, ev}, 16'h0000);
    wait_n(1);
    check({lost, ev}, {14'h0, exp, exp});
    check(cut, exp && a == ACT_FREERUN);
    check(dstop, exp && a == ACT_STOP);
    wait_n(1);
    check({lost, ev}, {14'h0, exp, 1'b0});
    volt = 12'hFFF;
    curr = 12'hFFF;
    kp_lost = 1'b0;
    wait_n(4);
    check({lost, cut, dstop}, 16'h0000);
  endtask
  // ----------------------------------------
  // Timer restart and one-cycle timeout
  // ----------------------------------------
  task automatic t_timer();
    src = SRC_VOLT;
    crit = CRIT_BELOW;
    act = ACT_NONE;
    volt = 12'h0C7;
    wait_n(2);
    // One clean cycle must restart the wait
    volt = 12'hFFF;
    wait_n(1);
    volt = 12'h0C7;
    wait_n(3);
    check(lost, 16'h0000);
    wait_n(1);
    check({lost, ev}, 16'h0003);
    volt = 12'hFFF;
    tmo = 16'h0001;
    wait_n(4);
    check(lost, 16'h0000);
    volt = 12'h0C7;
    wait_n(2);
    check({lost, ev}, 16'h0003);
    volt = 12'hFFF;
    tmo = 16'h0003;
    wait_n(4);
    check(lost, 16'h0000);
  endtask
  task automatic tally_and_finish();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Cut a hang short well past the planned run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    wait_n(4);
    check({lost, ev, cut, dstop, jact, sidx, ridx}, 16'h0000);
    check(fvec(), 16'h0000);
    rst = 1'b0;
    wait_n(2);
    t_select(1'b0);
    t_select(1'b1);
    t_funcs();
    t_loss(SRC_VOLT, CRIT_BELOW, ACT_NONE, 12'h0C7, 12'hFFF, 0, 1);
    t_loss(SRC_VOLT, CRIT_BELOW, ACT_FREERUN, 12'h0C8, 12'hFFF, 0, 0);
    t_loss(SRC_VOLT, CRIT_HALF, ACT_FREERUN, 12'h096, 12'hFFF, 0, 0);
    t_loss(SRC_VOLT, CRIT_HALF, ACT_FREERUN, 12'h063, 12'hFFF, 0, 1);
    t_loss(SRC_CURR, CRIT_BELOW, ACT_STOP, 12'hFFF, 12'h18F, 0, 1);
    t_loss(SRC_SUM, CRIT_BELOW, ACT_STOP, 12'hFFF, 12'h000, 0, 1);
    t_loss(SRC_VOLT, CRIT_NONE, ACT_STOP, 12'h000, 12'h000, 0, 0);
    t_loss(SRC_KEYPAD1, CRIT_BELOW, ACT_NONE, 12'h000, 12'h000, 0, 0);
    t_loss(SRC_KEYPAD2, CRIT_BELOW, ACT_STOP, 12'hFFF, 12'hFFF, 1, 1);
    t_loss(3'h5, CRIT_BELOW, ACT_STOP, 12'h000, 12'h000, 1, 0);
    t_timer();
    tally_and_finish();
  end
endmodule // drive_input_function_select_bench
